// ==== fscr_assertions.sv ====
`timescale 1ns/1ps
module fscr_assertions (
	input wire REF_CLK_I, input wire SRST_I, input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I, input wire AVS_WRITE_I, input wire AVS_WAITREQUEST_O,
	input wire [31:0] AVS_READDATA_O, input wire QUAD_IO_SELECT_O,
	input wire WP_PIN_ENABLE_O, input wire RESET_PIN_ENABLE_O,
	input wire ADDRESS_WIDTH_INDICATOR_O, input wire [1:0] DUMMY_CYCLE_SELECT_O,
	input wire [2:0] OUTPUT_DRIVE_SELECT_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);
	sequence ack_s; !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O; endsequence
	sequence ans_s(ad); !AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == ad; endsequence
	AST_ANSWER: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |=> ack_s) else $error("ack");
	AST_PINS: assert property ({WP_PIN_ENABLE_O, RESET_PIN_ENABLE_O} == {2{!QUAD_IO_SELECT_O}})
		else $error("pin");
	AST_QUAD: assert property (ans_s(4'h0) |-> AVS_READDATA_O[6] == QUAD_IO_SELECT_O)
		else $error("quad");
	AST_DC: assert property (ans_s(4'h1) |-> AVS_READDATA_O[7:6] == DUMMY_CYCLE_SELECT_O)
		else $error("dc");
	AST_ADDR4: assert property (ans_s(4'h1) |-> AVS_READDATA_O[5] == ADDRESS_WIDTH_INDICATOR_O)
		else $error("addr4");
	AST_ODS: assert property (ans_s(4'h1) |-> AVS_READDATA_O[2:0] == OUTPUT_DRIVE_SELECT_O)
		else $error("ods");
	AST_RSV: assert property (ans_s(4'h1) |-> !AVS_READDATA_O[4]) else $error("rsv");
	AST_HOLD: assert property ($changed(ADDRESS_WIDTH_INDICATOR_O) |-> $past(AVS_WRITE_I, 2)
		&& $past(AVS_ADDRESS_I, 2) == 4'h2) else $error("hold");
endmodule // fscr_assertions
bind fscr_top fscr_assertions u_chk (.*);

// ==== fscr_busy_timer.v ====
`timescale 1ns/1ps
module fscr_busy_timer #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire srst_i,
	// Control
	input wire start_i,
	input wire [WIDTH-1:0] load_i,
	// Status
	output wire busy_o
);
	reg [WIDTH-1:0] cnt_q;
	always @(posedge clk_i)
	begin
		if (srst_i)
			cnt_q <= {WIDTH{1'b0}};
		else if (start_i)
			cnt_q <= load_i;
		else if (cnt_q != {WIDTH{1'b0}})
			cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
	end
	assign busy_o = (cnt_q != {WIDTH{1'b0}});
endmodule // fscr_busy_timer

// ==== fscr_engine_model.sv ====
`timescale 1ns/1ps
module fscr_engine_model (input wire clk_i, input wire busy_i, output reg busy_o);
	// Program/erase engine: busy level follows the request one clock later
	always @(posedge clk_i)
		busy_o <= busy_i;
endmodule // fscr_engine_model

// ==== fscr_protect_map.v ====
`timescale 1ns/1ps
`include "fscr_regs.vh"
module fscr_protect_map (
	// Protection settings
	input wire [3:0] block_protect_field_i,
	input wire protect_origin_select_i,
	// Target block and result
	input wire [3:0] block_i,
	output wire protected_o
);
	// Level n protects 2^(n-1) blocks from the chosen end; 5 and above protect all
	wire [4:0] span = (block_protect_field_i == 4'h0) ? 5'h00 :
		(block_protect_field_i > 4'h4) ? 5'h10 :
		(5'h01 << (block_protect_field_i - 4'h1));
	wire [4:0] idx = protect_origin_select_i ? {1'b0, block_i} : (5'h0F - {1'b0, block_i});
	assign protected_o = (idx < span); // RL3 RL8
endmodule // fscr_protect_map

// ==== fscr_regs.vh ====
`ifndef FSCR_REGS_VH
`define FSCR_REGS_VH
// Avalon word addresses (byte address = 4 * word index)
`define FSCR_ADDR_STATUS 4'h0
`define FSCR_ADDR_CONFIG 4'h1
`define FSCR_ADDR_CMD 4'h2
`define FSCR_ADDR_ENGINE 4'h3
// Status register fields
`define FSCR_SR_LOCK 7
`define FSCR_SR_QUAD 6
`define FSCR_SR_BP_HI 5
`define FSCR_SR_BP_LO 2
`define FSCR_SR_WEL 1
`define FSCR_SR_WIP 0
// Configuration register fields
`define FSCR_CR_DC_HI 7
`define FSCR_CR_DC_LO 6
`define FSCR_CR_ADDR4 5
`define FSCR_CR_RSV 4
`define FSCR_CR_ORIGIN 3
`define FSCR_CR_ODS_HI 2
`define FSCR_CR_ODS_LO 0
// Command register bits
`define FSCR_CMD_WREN 0
`define FSCR_CMD_WRDI 1
`define FSCR_CMD_EN4B 2
`define FSCR_CMD_EX4B 3
// Reset values
`define FSCR_SR_RESET 8'h00
`define FSCR_CR_RESET 8'h07
// Writable masks
`define FSCR_SR_WMASK 8'hFC
`define FSCR_CR_WMASK 8'hCF
// Busy time of a register write in cycles
`define FSCR_WRSR_BUSY 16'h0010
`endif

// ==== fscr_top.v ====
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "fscr_regs.vh"
// Overview of operation
// RL1 - Lock bit set refuses status register writes
// RL2 - Quad select disables write-protect and reset pins
// RL3 - Block protect field guards region from writes
// RL4 - Status bit 1 shows write enable latch
// RL5 - Status bit 0 shows program/erase busy
// RL6 - Config bits 7:6 hold dummy cycle select
// RL7 - Config bit 5 shows four-byte address mode
// RL8 - Config bit 3 picks bottom or top origin
// RL9 - Config bits 2:0 hold output drive select
// RL10 - Address width bit changes only by command
// RL11 - Config bit 4 reads zero, ignores writes
module fscr_top #(
	parameter BUSY_WIDTH = 16
) (
	// Clock and reset
	input wire REF_CLK_I,
	input wire SRST_I,
	// Avalon-MM slave
	input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	output reg [31:0] AVS_READDATA_O,
	output reg AVS_WAITREQUEST_O,
	// Pin functions and engine
	input wire WP_N_I,
	input wire ENGINE_BUSY_I,
	input wire [3:0] ENGINE_BLOCK_I,
	output reg QUAD_IO_SELECT_O,
	output reg WP_PIN_ENABLE_O,
	output reg RESET_PIN_ENABLE_O,
	output reg ADDRESS_WIDTH_INDICATOR_O,
	output reg [1:0] DUMMY_CYCLE_SELECT_O,
	output reg [2:0] OUTPUT_DRIVE_SELECT_O,
	output reg BLOCK_PROTECTED_O
);
	reg [5:0] sr_store_q;
	reg [7:0] cr_store_q;
	reg wel_q;
	reg addr4_q;
	reg ack_q;
	wire busy;
	wire is_prot;
	wire wr_busy;
	wire start_busy;
	wire access = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
	// Writes commit at the edge where waitrequest is sampled low
	wire wr = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];
	wire [7:0] wdata = AVS_WRITEDATA_I[7:0];
	wire [7:0] sr_reset_val = `FSCR_SR_RESET;
	wire [7:0] sr_wmask = `FSCR_SR_WMASK;
	// Quad mode frees the write-protect pin, else it guards the lock
	wire wp_active = ~sr_store_q[`FSCR_SR_QUAD - 2] & ~WP_N_I; // RL2
	wire sr_locked = sr_store_q[`FSCR_SR_LOCK - 2] & wp_active;
	wire hit_sr = wr & (AVS_ADDRESS_I == `FSCR_ADDR_STATUS);
	wire hit_cr = wr & (AVS_ADDRESS_I == `FSCR_ADDR_CONFIG);
	wire hit_cmd = wr & (AVS_ADDRESS_I == `FSCR_ADDR_CMD);
	// Register writes need the latch set and no cycle running
	wire reg_ok = wel_q & ~busy & ~ENGINE_BUSY_I;
	wire sr_take = hit_sr & reg_ok & ~sr_store_q[`FSCR_SR_LOCK - 2]; // RL1
	wire cr_take = hit_cr & reg_ok & ~sr_locked;
	assign start_busy = sr_take | cr_take;
	wire [7:0] status_view = {sr_store_q, wel_q, busy | ENGINE_BUSY_I}; // RL4 RL5
	wire [7:0] config_view = {cr_store_q[7:6], addr4_q, 1'b0, cr_store_q[3:0]}; // RL7 RL11

	fscr_busy_timer #(
		.WIDTH(BUSY_WIDTH)
	) u_busy (
		.clk_i(REF_CLK_I),
		.srst_i(SRST_I),
		.start_i(start_busy),
		.load_i(`FSCR_WRSR_BUSY),
		.busy_o(busy)
	);

	fscr_protect_map u_prot (
		.block_protect_field_i(sr_store_q[`FSCR_SR_BP_HI-2:`FSCR_SR_BP_LO-2]),
		.protect_origin_select_i(cr_store_q[`FSCR_CR_ORIGIN]),
		.block_i(ENGINE_BLOCK_I),
		.protected_o(is_prot)
	);

	// Bus handshake: one wait cycle, answer on the second edge
	always @(posedge REF_CLK_I)
	begin
		if (SRST_I)
		begin
			ack_q <= 1'b0;
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h00000000;
		end
		else
		begin
			ack_q <= access;
			AVS_WAITREQUEST_O <= ~access;
			if (AVS_READ_I & ~ack_q)
			begin
				case (AVS_ADDRESS_I)
					`FSCR_ADDR_STATUS: AVS_READDATA_O <= {24'h000000, status_view};
					`FSCR_ADDR_CONFIG: AVS_READDATA_O <= {24'h000000, config_view};
					`FSCR_ADDR_ENGINE: AVS_READDATA_O <= {31'h00000000, is_prot};
					default: AVS_READDATA_O <= 32'h00000000;
				endcase
			end
		end
	end

	// Register contents
	always @(posedge REF_CLK_I)
	begin
		if (SRST_I)
		begin
			sr_store_q <= sr_reset_val[7:2];
			cr_store_q <= `FSCR_CR_RESET;
			wel_q <= 1'b0;
			addr4_q <= 1'b0;
		end
		else
		begin
			if (sr_take)
				sr_store_q <= wdata[7:2] & sr_wmask[7:2]; // RL1 RL3
			if (cr_take)
				cr_store_q <= wdata & `FSCR_CR_WMASK; // RL6 RL9 RL10 RL11
			if (start_busy | hit_cmd & wdata[`FSCR_CMD_WRDI])
				wel_q <= 1'b0;
			else if (hit_cmd & wdata[`FSCR_CMD_WREN])
				wel_q <= 1'b1; // RL4
			if (hit_cmd & wdata[`FSCR_CMD_EN4B])
				addr4_q <= 1'b1; // RL10
			else if (hit_cmd & wdata[`FSCR_CMD_EX4B])
				addr4_q <= 1'b0; // RL10
		end
	end

	// Registered views of the settings
	always @(posedge REF_CLK_I)
	begin
		if (SRST_I)
		begin
			QUAD_IO_SELECT_O <= 1'b0;
			WP_PIN_ENABLE_O <= 1'b1;
			RESET_PIN_ENABLE_O <= 1'b1;
			ADDRESS_WIDTH_INDICATOR_O <= 1'b0;
			DUMMY_CYCLE_SELECT_O <= 2'h0;
			OUTPUT_DRIVE_SELECT_O <= 3'h7;
			BLOCK_PROTECTED_O <= 1'b0;
		end
		else
		begin
			QUAD_IO_SELECT_O <= sr_store_q[`FSCR_SR_QUAD - 2]; // RL2
			WP_PIN_ENABLE_O <= ~sr_store_q[`FSCR_SR_QUAD - 2]; // RL2
			RESET_PIN_ENABLE_O <= ~sr_store_q[`FSCR_SR_QUAD - 2]; // RL2
			ADDRESS_WIDTH_INDICATOR_O <= addr4_q; // RL7
			DUMMY_CYCLE_SELECT_O <= cr_store_q[`FSCR_CR_DC_HI:`FSCR_CR_DC_LO]; // RL6
			OUTPUT_DRIVE_SELECT_O <= cr_store_q[`FSCR_CR_ODS_HI:`FSCR_CR_ODS_LO]; // RL9
			BLOCK_PROTECTED_O <= is_prot; // RL3
		end
	end
endmodule // fscr_top

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	reg c = 0, rst = 1, rd = 0, wr = 0, eb = 0, wpn = 1;
	wire ai;
	wire [1:0] dc;
	wire [2:0] ods;
	reg [3:0] a = 4'h0;
	reg [31:0] wd = 32'h0, r;
	wire [31:0] q;
	wire w, qs, wp, rs, bp, eo;
	integer err_count = 0, total_checks = 0;
	initial forever #5 c = ~c;
	fscr_engine_model u_eng (.clk_i(c), .busy_i(eb), .busy_o(eo));
	fscr_top u_dut (.REF_CLK_I(c), .SRST_I(rst), .AVS_ADDRESS_I(a), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(q),
		.AVS_WAITREQUEST_O(w), .WP_N_I(wpn), .ENGINE_BUSY_I(eo), .ENGINE_BLOCK_I(4'h9),
		.QUAD_IO_SELECT_O(qs), .WP_PIN_ENABLE_O(wp), .RESET_PIN_ENABLE_O(rs),
		.ADDRESS_WIDTH_INDICATOR_O(ai), .DUMMY_CYCLE_SELECT_O(dc), .OUTPUT_DRIVE_SELECT_O(ods),
		.BLOCK_PROTECTED_O(bp));
	task chk(input [31:0] e, input [31:0] g);
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("unexpected %0t exp %h got %h", $time, e, g);
		end
	endtask
	task xfer(input x, input [3:0] ad, input [7:0] d);
		@(posedge c);
		{a, wd} <= {ad, 24'h0, d};
		{rd, wr} <= {!x, x};
		@(posedge c);
		while (w !== 1'b0)
			@(posedge c);
		r = q;
		{rd, wr} <= 2'b00;
	endtask
	task rc(input [3:0] ad, input [7:0] e);
		xfer(0, ad, 8'h00);
		chk(e, r);
	endtask
	// Write enable, register write, then let the write busy time run out
	task sw(input [3:0] ad, input [7:0] d);
		xfer(1, 4'h2, 8'h01);
		xfer(1, ad, d);
		repeat (20) @(posedge c);
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task t_status;
		rc(4'hF, 8'h00);
		xfer(1, 4'h2, 8'h01);
		rc(4'h0, 8'h02);
		xfer(1, 4'h0, 8'h7C);
		rc(4'h0, 8'h7D);
		eb <= 1;
		repeat (20) @(posedge c);
		rc(4'h0, 8'h7D);
		chk(4'h9, {qs, wp, rs, bp});
		rc(4'h3, 8'h01);
		eb <= 0;
	endtask
	task t_cfg_lock;
		rc(4'h1, 8'h07);
		chk(6'h07, {ai, dc, ods});
		sw(4'h1, 8'hFF);
		rc(4'h1, 8'hCF);
		xfer(1, 4'h2, 8'h04);
		rc(4'h1, 8'hEF);
		chk(6'h3F, {ai, dc, ods});
		sw(4'h0, 8'h80);
		sw(4'h0, 8'h40);
		wpn <= 0;
		xfer(1, 4'h1, 8'h00);
		rc(4'h1, 8'hEF);
		wpn <= 1;
		xfer(1, 4'h2, 8'h02);
		rc(4'h0, 8'h80);
	endtask
	initial
	begin
		repeat (6) @(posedge c);
		rst <= 0;
		t_status;
		t_cfg_lock;
		close_out;
	end
	initial
	begin
		#20000;
		err_count = err_count + 1;
		close_out;
	end
endmodule // tb
